// ### design/ums_device.sv
// Device end of the ultrasonic measurement sequencer: START, TX burst and STOP generation.
// Assumes the host keeps its enable and reset waits; echo comparator outputs are synchronous.
//
// Behaviour
// - Trigger starts cycle; device emits one START.
// - START begins first in every measurement cycle.
// - TX burst begins at START rising edge.
// - Divider 2h: START 1,2,3 periods wide.
// - Host waits 50 ns after enable before trigger.
// - Host waits 3.05 us after reset.
// - Threshold comparator qualifies, second makes STOP.
// - Detected echo crossings driven as STOP pulses.
// - Host-written settings apply to following cycles.
// - TX frequency is reference clock over 2^(div+1).
`timescale 1ns/1ns
`default_nettype none
module ums_device #(
    parameter int LISTEN_CYC = 4000
) (
    input  wire logic clk,
    input  wire logic rst,
    ums_link_if.device link,
    input  wire logic echo_thresh,
    input  wire logic echo_zero
);
    // The listen counter and the widest TX period must both fit in CNT_W bits.
    // A wider divider field would need a wider phase counter as well.
    if (LISTEN_CYC < 1 || LISTEN_CYC >= (1 << ums_pkg::CNT_W)) begin : g_bad_listen
        $error("LISTEN_CYC out of range");
    end
    if ((2 << ((1 << ums_pkg::DIV_W) - 1)) >= (1 << ums_pkg::CNT_W)) begin : g_bad_div
        $error("divider range exceeds counter width");
    end
    if (ums_pkg::START_CAP >= (1 << ums_pkg::NUM_TX_W)) begin : g_bad_cap
        $error("start cap exceeds pulse count width");
    end

    ums_pkg::ums_state_t           state_q, state_d;
    logic [ums_pkg::DIV_W-1:0]     div_q, div_d;
    logic [ums_pkg::NUM_TX_W-1:0]  num_q, num_d;
    logic [ums_pkg::DIV_W-1:0]     run_div_q, run_div_d;
    logic [ums_pkg::NUM_TX_W-1:0]  run_num_q, run_num_d;
    logic [ums_pkg::CNT_W-1:0]     phase_q, phase_d;
    logic [ums_pkg::NUM_TX_W-1:0]  pulses_q, pulses_d;
    logic [ums_pkg::CNT_W-1:0]     listen_q, listen_d;
    logic                          tx_q, tx_d;
    logic                          start_q, start_d;
    logic                          stop_q, stop_d;
    logic                          qual_q, qual_d;
    logic                          zero_prev_q, zero_prev_d;
    logic                          trig_prev_q, trig_prev_d;
    logic [ums_pkg::CNT_W-1:0]     half_period;
    logic [ums_pkg::NUM_TX_W-1:0]  start_periods;
    logic                          listen_on;

    // The reference clock here is clk, so a half TX period is 2^div cycles.
    assign half_period   = ums_pkg::CNT_W'(1) << run_div_q;
    assign start_periods = (run_num_q > ums_pkg::NUM_TX_W'(ums_pkg::START_CAP))
                         ? ums_pkg::NUM_TX_W'(ums_pkg::START_CAP) : run_num_q;

    // Settings land in shadow copies; a running cycle keeps its own snapshot.
    // The trigger history resets high so a trigger held across reset is not taken as new.
    always_comb begin
        div_d       = div_q;
        num_d       = num_q;
        trig_prev_d = link.trigger;
        if (link.cfg_write) begin
            div_d = link.cfg_div;
            num_d = link.cfg_num_tx;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            div_q       <= ums_pkg::DIV_RESET;
            num_q       <= ums_pkg::NUM_TX_RESET;
            trig_prev_q <= 1'b1;
        end else begin
            div_q       <= div_d;
            num_q       <= num_d;
            trig_prev_q <= trig_prev_d;
        end
    end

    always_comb begin
        state_d     = state_q;
        run_div_d   = run_div_q;
        run_num_d   = run_num_q;
        phase_d     = phase_q;
        pulses_d    = pulses_q;
        listen_d    = listen_q;
        tx_d        = tx_q;
        start_d     = start_q;
        case (state_q)
            ums_pkg::UMS_IDLE: begin
                tx_d    = 1'b0;
                start_d = 1'b0;
                if (link.enable && link.trigger && !trig_prev_q && num_q != '0) begin
                    state_d   = ums_pkg::UMS_BURST;
                    run_div_d = div_q;
                    run_num_d = num_q;
                    start_d   = 1'b1;
                    tx_d      = 1'b1;
                    phase_d   = '0;
                    pulses_d  = '0;
                end
            end
            ums_pkg::UMS_BURST: begin
                if (phase_q == (half_period << 1) - ums_pkg::CNT_W'(1)) begin
                    phase_d  = '0;
                    pulses_d = pulses_q + ums_pkg::NUM_TX_W'(1);
                    if (pulses_q + ums_pkg::NUM_TX_W'(1) >= start_periods) begin
                        start_d = 1'b0;
                    end
                    if (pulses_q + ums_pkg::NUM_TX_W'(1) >= run_num_q) begin
                        tx_d     = 1'b0;
                        state_d  = ums_pkg::UMS_LISTEN;
                        listen_d = '0;
                    end else begin
                        tx_d = 1'b1;
                    end
                end else begin
                    phase_d = phase_q + ums_pkg::CNT_W'(1);
                    if (phase_q == half_period - ums_pkg::CNT_W'(1)) begin
                        tx_d = 1'b0;
                    end
                end
            end
            ums_pkg::UMS_LISTEN: begin
                start_d  = 1'b0;
                listen_d = listen_q + ums_pkg::CNT_W'(1);
                if (listen_q == ums_pkg::CNT_W'(LISTEN_CYC - 1)) begin
                    state_d = ums_pkg::UMS_IDLE;
                end
            end
            default: begin
                state_d = ums_pkg::UMS_IDLE;
            end
        endcase
        if (!link.enable) begin
            state_d = ums_pkg::UMS_IDLE;
            tx_d    = 1'b0;
            start_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q     <= ums_pkg::UMS_IDLE;
            run_div_q   <= ums_pkg::DIV_RESET;
            run_num_q   <= ums_pkg::NUM_TX_RESET;
            phase_q     <= '0;
            pulses_q    <= '0;
            listen_q    <= '0;
            tx_q        <= 1'b0;
            start_q     <= 1'b0;
        end else begin
            state_q     <= state_d;
            run_div_q   <= run_div_d;
            run_num_q   <= run_num_d;
            phase_q     <= phase_d;
            pulses_q    <= pulses_d;
            listen_q    <= listen_d;
            tx_q        <= tx_d;
            start_q     <= start_d;
        end
    end

    // STOP is only raised while the listen window goes on into the next cycle, so a
    // crossing on its last cycle or during an enable abort never shows outside busy.
    assign listen_on = (state_q == ums_pkg::UMS_LISTEN) && (state_d == ums_pkg::UMS_LISTEN);

    always_comb begin
        qual_d      = qual_q;
        stop_d      = 1'b0;
        zero_prev_d = echo_zero;
        if (!listen_on) begin
            qual_d = 1'b0;
        end else begin
            if (echo_thresh) begin
                qual_d = 1'b1;
            end
            // Only rising zero-crossings in or after the cycle of qualification become STOP pulses.
            if ((qual_q || echo_thresh) && echo_zero && !zero_prev_q) begin
                stop_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stop_q      <= 1'b0;
            qual_q      <= 1'b0;
            zero_prev_q <= 1'b0;
        end else begin
            stop_q      <= stop_d;
            qual_q      <= qual_d;
            zero_prev_q <= zero_prev_d;
        end
    end

    assign link.start_pulse = start_q;
    assign link.stop_pulse  = stop_q;
    assign link.tx_out      = tx_q;
    assign link.busy        = (state_q != ums_pkg::UMS_IDLE);
endmodule
`default_nettype wire

// ### design/ums_pkg.sv
// Package for the ultrasonic measurement sequencer: settings, timing and state encodings.
// Assumes a single 20 MHz system clock shared by both ends.
package ums_pkg;
    localparam int CLK_PERIOD_NS      = 50;
    localparam int EN_TRIG_WAIT_NS    = 50;
    localparam int EN_TRIG_WAIT_CYC   = (EN_TRIG_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RES_TRIG_WAIT_NS   = 3050;
    localparam int RES_TRIG_WAIT_CYC  = (RES_TRIG_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DIV_W              = 3;
    localparam int NUM_TX_W           = 5;
    localparam int START_CAP          = 3;
    localparam int CNT_W              = 16;
    localparam logic [DIV_W-1:0]    DIV_RESET    = 3'h2;
    localparam logic [NUM_TX_W-1:0] NUM_TX_RESET = 5'h01;
    localparam int ECHO_GAP_CYC       = 4;

    typedef enum logic [1:0] {
        UMS_IDLE  = 2'b00,
        UMS_BURST = 2'b01,
        UMS_LISTEN = 2'b10
    } ums_state_t;
endpackage

// ### design/ums_link_if.sv
// Interface carrying the pins between the sequencer device end and its host end.
// Assumes both ends run on the same clock; config stands in for the serial settings path.
`timescale 1ns/1ns
`default_nettype none
interface ums_link_if;
    logic                          enable;
    logic                          trigger;
    logic                          cfg_write;
    logic [ums_pkg::DIV_W-1:0]     cfg_div;
    logic [ums_pkg::NUM_TX_W-1:0]  cfg_num_tx;
    logic                          start_pulse;
    logic                          stop_pulse;
    logic                          tx_out;
    logic                          busy;

    modport device (
        input  enable,
        input  trigger,
        input  cfg_write,
        input  cfg_div,
        input  cfg_num_tx,
        output start_pulse,
        output stop_pulse,
        output tx_out,
        output busy
    );
    modport host (
        output enable,
        output trigger,
        output cfg_write,
        output cfg_div,
        output cfg_num_tx,
        input  start_pulse,
        input  stop_pulse,
        input  tx_out,
        input  busy
    );
endinterface
`default_nettype wire

// ### design/ums_host.sv
// Host end: configures the sequencer, honours enable and reset waits, triggers, times START to STOP.
// Assumes the same clock as the device end; the user side issues one-cycle requests.
`timescale 1ns/1ns
`default_nettype none
module ums_host (
    input  wire logic                         clk,
    input  wire logic                         rst,
    ums_link_if.host                          link,
    input  wire logic                         enable_req,
    input  wire logic                         cfg_req,
    input  wire logic [ums_pkg::DIV_W-1:0]    cfg_div_in,
    input  wire logic [ums_pkg::NUM_TX_W-1:0] cfg_num_in,
    input  wire logic                         meas_req,
    output logic                              ready,
    output logic                              tof_valid,
    output logic [ums_pkg::CNT_W-1:0]         tof_cycles
);
    logic [ums_pkg::CNT_W-1:0]     wait_q, wait_d;
    logic                          en_q, en_d;
    logic                          trig_q, trig_d;
    logic                          cfgw_q, cfgw_d;
    logic [ums_pkg::DIV_W-1:0]     div_q, div_d;
    logic [ums_pkg::NUM_TX_W-1:0]  num_q, num_d;
    logic                          timing_q, timing_d;
    logic [ums_pkg::CNT_W-1:0]     tof_cnt_q, tof_cnt_d;
    logic                          tof_valid_q, tof_valid_d;
    logic [ums_pkg::CNT_W-1:0]     tof_q, tof_d;

    assign ready = en_q && (wait_q == '0) && !link.busy && !trig_q;

    always_comb begin
        wait_d      = (wait_q != '0) ? wait_q - ums_pkg::CNT_W'(1) : wait_q;
        en_d        = enable_req;
        trig_d      = 1'b0;
        cfgw_d      = 1'b0;
        div_d       = div_q;
        num_d       = num_q;
        timing_d    = timing_q;
        tof_cnt_d   = tof_cnt_q;
        tof_valid_d = 1'b0;
        tof_d       = tof_q;
        // Enabling only lengthens the wait, so it cannot cut short the wait after reset.
        if (enable_req && !en_q && wait_d < ums_pkg::CNT_W'(ums_pkg::EN_TRIG_WAIT_CYC)) begin
            wait_d = ums_pkg::CNT_W'(ums_pkg::EN_TRIG_WAIT_CYC);
        end
        if (cfg_req) begin
            cfgw_d = 1'b1;
            div_d  = cfg_div_in;
            num_d  = cfg_num_in;
        end
        if (meas_req && ready) begin
            trig_d = 1'b1;
        end
        if (link.start_pulse && !timing_q) begin
            timing_d  = 1'b1;
            tof_cnt_d = '0;
        end else if (timing_q) begin
            tof_cnt_d = tof_cnt_q + ums_pkg::CNT_W'(1);
            if (link.stop_pulse) begin
                tof_valid_d = 1'b1;
                tof_d       = tof_cnt_q + ums_pkg::CNT_W'(1);
                timing_d    = 1'b0;
            end else if (!link.busy) begin
                timing_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wait_q      <= ums_pkg::CNT_W'(ums_pkg::RES_TRIG_WAIT_CYC);
            en_q        <= 1'b0;
            trig_q      <= 1'b0;
            cfgw_q      <= 1'b0;
            div_q       <= ums_pkg::DIV_RESET;
            num_q       <= ums_pkg::NUM_TX_RESET;
            timing_q    <= 1'b0;
            tof_cnt_q   <= '0;
            tof_valid_q <= 1'b0;
            tof_q       <= '0;
        end else begin
            wait_q      <= wait_d;
            en_q        <= en_d;
            trig_q      <= trig_d;
            cfgw_q      <= cfgw_d;
            div_q       <= div_d;
            num_q       <= num_d;
            timing_q    <= timing_d;
            tof_cnt_q   <= tof_cnt_d;
            tof_valid_q <= tof_valid_d;
            tof_q       <= tof_d;
        end
    end

    assign link.enable     = en_q;
    assign link.trigger    = trig_q;
    assign link.cfg_write  = cfgw_q;
    assign link.cfg_div    = div_q;
    assign link.cfg_num_tx = num_q;
    assign tof_valid       = tof_valid_q;
    assign tof_cycles      = tof_q;
endmodule
`default_nettype wire

// ### sim/ums_checker.sv
// Checker for the link between the device and host ends of the sequencer.
// Assumes one clock and a synchronous active-high reset shared by both ends.
`timescale 1ns/1ns
`default_nettype none
module ums_checker (
    input wire logic                         clk,
    input wire logic                         rst,
    input wire logic                         enable,
    input wire logic                         trigger,
    input wire logic                         cfg_write,
    input wire logic [ums_pkg::DIV_W-1:0]    cfg_div,
    input wire logic [ums_pkg::NUM_TX_W-1:0] cfg_num_tx,
    input wire logic                         start_pulse,
    input wire logic                         stop_pulse,
    input wire logic                         tx_out,
    input wire logic                         busy
);
    // Settings are mirrored here and frozen at each trigger, as the device does.
    logic [ums_pkg::DIV_W-1:0]    div_q;
    logic [ums_pkg::DIV_W-1:0]    run_div_q;
    logic [ums_pkg::NUM_TX_W-1:0] num_q;
    logic [11:0]                  width_q;
    logic [11:0]                  start_cnt_q;
    logic [11:0]                  tx_cnt_q;
    logic [7:0]                   rst_cnt_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    always_ff @(posedge clk) begin
        if (rst) begin
            div_q <= ums_pkg::DIV_RESET;
            run_div_q <= ums_pkg::DIV_RESET;
            num_q <= ums_pkg::NUM_TX_RESET;
            width_q <= 12'h000;
            start_cnt_q <= 12'h000;
            tx_cnt_q <= 12'h000;
            rst_cnt_q <= 8'h00;
        end else begin
            if (cfg_write) begin
                div_q <= cfg_div;
                num_q <= cfg_num_tx;
            end
            if (trigger && !busy) begin
                run_div_q <= div_q;
                width_q <= 12'(num_q > 5'h03 ? 5'h03 : num_q) << (int'(div_q) + 1);
            end
            // Saturates so that a long run never wraps back below the wait.
            rst_cnt_q <= (rst_cnt_q == 8'hFF) ? rst_cnt_q : rst_cnt_q + 8'h01;
            start_cnt_q <= start_pulse ? start_cnt_q + 12'h001 : 12'h000;
            tx_cnt_q <= tx_out ? tx_cnt_q + 12'h001 : 12'h000;
        end
    end
    a_trig_starts: assert property ($rose(trigger) && enable && !busy && num_q != 5'h00
        |=> $rose(start_pulse)) else $error("trigger did not start a cycle");
    a_start_cause: assert property ($rose(start_pulse) |-> $past(trigger) && !$past(busy))
        else $error("start without a trigger taken in idle");
    a_start_first: assert property ($rose(busy) |-> $rose(start_pulse))
        else $error("cycle began without start");
    a_tx_aligned: assert property ($rose(start_pulse) |-> $rose(tx_out))
        else $error("burst not aligned to start");
    a_start_width: assert property ($fell(start_pulse) && enable |-> start_cnt_q == width_q)
        else $error("start width wrong");
    a_tx_half: assert property ($fell(tx_out) |-> tx_cnt_q == (12'h001 << run_div_q))
        else $error("transmit half period wrong");
    a_stop_listen: assert property (stop_pulse |-> busy && !start_pulse)
        else $error("stop outside listen");
    a_stop_single: assert property (stop_pulse |=> !stop_pulse)
        else $error("stop wider than one cycle");
    a_enable_wait: assert property ($rose(trigger) |-> $past(enable))
        else $error("trigger too soon after enable");
    a_reset_wait: assert property ($rose(trigger) |-> rst_cnt_q >= ums_pkg::RES_TRIG_WAIT_CYC)
        else $error("trigger too soon after reset");
endmodule
`default_nettype wire

// ### sim/ums_tb.sv
// Testbench joining the device and host ends; drives both user sides.
// Assumes a 20 MHz clock and a shortened listen window of 50 cycles.
`timescale 1ns/1ns
`default_nettype none
module ums_tb;
    logic                         clk = 1'b0;
    logic                         rst = 1'b1;
    logic                         en_req = 1'b1;
    logic                         cfg_req = 1'b0;
    logic                         meas_req = 1'b0;
    logic                         echo_thresh = 1'b0;
    logic                         echo_zero = 1'b0;
    logic [ums_pkg::DIV_W-1:0]    div_in = 3'h2;
    logic [ums_pkg::NUM_TX_W-1:0] num_in = 5'h01;
    logic                         ready;
    logic                         tof_valid;
    logic [ums_pkg::CNT_W-1:0]    tof_cycles;
    int                           errors = 0;
    int                           num_checks = 0;
    int                           k;
    // Divider, pulse count, expected start width in cycles.
    int rows [6][3] = '{'{2, 1, 8}, '{2, 2, 16}, '{2, 3, 24}, '{2, 9, 24}, '{0, 5, 6}, '{1, 4, 12}};
    ums_link_if link ();
    ums_device #(.LISTEN_CYC(50)) ums_device_i (.clk(clk), .rst(rst), .link(link),
        .echo_thresh(echo_thresh), .echo_zero(echo_zero));
    ums_host ums_host_i (.clk(clk), .rst(rst), .link(link), .enable_req(en_req),
        .cfg_req(cfg_req), .cfg_div_in(div_in), .cfg_num_in(num_in), .meas_req(meas_req),
        .ready(ready), .tof_valid(tof_valid), .tof_cycles(tof_cycles));
    ums_checker ums_checker_i (.clk(clk), .rst(rst), .enable(link.enable),
        .trigger(link.trigger), .cfg_write(link.cfg_write), .cfg_div(link.cfg_div),
        .cfg_num_tx(link.cfg_num_tx), .start_pulse(link.start_pulse),
        .stop_pulse(link.stop_pulse), .tx_out(link.tx_out), .busy(link.busy));
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        if (errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic do_reset();
        int n = 0;
        rst = 1'b1;
        repeat (12) step();
        chk("start in reset", 16'h0000, {15'h0, link.start_pulse});
        rst = 1'b0;
        while (ready !== 1'b1 && n < 300) begin
            step();
            n++;
        end
        chk("reset wait", 16'h0001, {15'h0, n >= ums_pkg::RES_TRIG_WAIT_CYC});
    endtask
    task automatic cfg(input int d, input int n);
        div_in = d[ums_pkg::DIV_W-1:0];
        num_in = n[ums_pkg::NUM_TX_W-1:0];
        cfg_req = 1'b1;
        step();
        cfg_req = 1'b0;
        step();
    endtask
    task automatic go();
        int n = 0;
        while (ready !== 1'b1 && n < 300) begin
            step();
            n++;
        end
        meas_req = 1'b1;
        step();
        meas_req = 1'b0;
    endtask
    task automatic measure(input int d, input int n, input int w);
        int b = n * (2 << d);
        int i = -1;
        int sw = 0;
        int txr = 0;
        int stp = 0;
        int tv = 0;
        logic tp = 1'b0;
        go();
        for (int c = 0; c < 400 && !(i > 0 && link.busy === 1'b0); c++) begin
            step();
            if (i < 0 && link.start_pulse === 1'b1) begin
                i = 0;
            end
            if (i >= 0) begin
                sw += int'(link.start_pulse === 1'b1);
                txr += int'(link.tx_out === 1'b1 && !tp);
                stp += int'(link.stop_pulse === 1'b1);
                tv += int'(tof_valid === 1'b1);
                // Two echo crossings well apart, both qualified by the threshold.
                echo_thresh = (i > b + 2 && i < b + 14);
                echo_zero = (i == b + 4 || i == b + 5 || i == b + 10 || i == b + 11);
                i++;
            end
            tp = (link.tx_out === 1'b1);
        end
        chk("start width", 16'(w), 16'(sw));
        chk("tx pulses", 16'(n), 16'(txr));
        chk("stop pulses", 16'h0002, 16'(stp));
        chk("tof results", 16'h0001, 16'(tv));
        chk("tof cycles", 16'(b + 5), tof_cycles);
    endtask
    initial begin
        #(20000 * 50);
        errors++;
        end_of_test();
    end
    initial begin
        do_reset();
        for (int r = 0; r < 6; r++) begin
            cfg(rows[r][0], rows[r][1]);
            measure(rows[r][0], rows[r][1], rows[r][2]);
        end
        do_reset();
        measure(2, 1, 8);
        cfg(0, 0);
        go();
        k = 0;
        repeat (20) begin
            step();
            k += int'(link.start_pulse === 1'b1);
        end
        chk("start for zero count", 16'h0000, 16'(k));
        cfg(2, 3);
        go();
        repeat (3) step();
        en_req = 1'b0;
        repeat (2) step();
        chk("abort start", 16'h0000, {15'h0, link.start_pulse});
        chk("abort busy", 16'h0000, {15'h0, link.busy});
        en_req = 1'b1;
        k = 0;
        while (ready !== 1'b1 && k < 300) begin
            step();
            k++;
        end
        chk("enable wait", 16'h0001, {15'h0, k > ums_pkg::EN_TRIG_WAIT_CYC});
        measure(2, 3, 24);
        end_of_test();
    end
endmodule
`default_nettype wire
